// [cycle_decode_pkg.sv]
// Shared constants and types for the instruction cycle sequencer and decoder
package cycle_decode_pkg;
  // Word and bus widths
  localparam int INSTR_W = 16;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int SEL_W = 5;
  // Clock rate and quarter length: one quarter per sys_clk period
  localparam int CLK_PERIOD_NS = 40;
  localparam int QUARTER_NS = 40;
  localparam int QUARTER_CYCLES = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUARTERS_PER_CYCLE = 4;
  // Field positions, port bit 15 is the first bit of the word as fetched
  localparam int OPCODE_MSB = 15;
  localparam int OPCODE_LSB = 13;
  localparam int SRC_MSB = 12;
  localparam int SRC_LSB = 8;
  localparam int RL_MSB = 7;
  localparam int RL_LSB = 5;
  localparam int DST_MSB = 4;
  localparam int DST_LSB = 0;
  localparam int LIT8_MSB = 7;
  localparam int LIT5_MSB = 4;
  // Inside a 5-bit selector: bus flag and bank bit
  localparam int SEL_BUS_BIT = 4;
  localparam int SEL_BANK_BIT = 3;
  // Registers with side effects on the bus
  localparam logic [4:0] REG_LEFT_ADDR = 5'h07;
  localparam logic [4:0] REG_RIGHT_ADDR = 5'h0F;
  localparam logic [4:0] REG_TRANSMIT_LITERAL_LEFT = 5'h0A;
  localparam logic [4:0] REG_TRANSMIT_LITERAL_RIGHT = 5'h0B;
  // Reset values
  localparam logic [12:0] PROG_ADDR_RESET = 13'h0000;
  localparam logic [15:0] INSTR_RESET = 16'h0000;
  localparam logic [7:0] BUS_IDLE_N = 8'hFF;

  typedef enum logic [1:0] {
    Q1 = 2'b00,
    Q2 = 2'b01,
    Q3 = 2'b10,
    Q4 = 2'b11
  } quarter_t;

  typedef enum logic [2:0] {
    op_move = 3'b000,
    op_add = 3'b001,
    op_and = 3'b010,
    op_xor = 3'b011,
    op_execute_indirect = 3'b100,
    op_branch_if_nonzero = 3'b101,
    op_transmit_literal = 3'b110,
    op_jump = 3'b111
  } opcode_t;

  typedef enum logic [2:0] {
    reg_reg_format = 3'b000,
    reg_bus_format = 3'b001,
    reg_branch_format = 3'b010,
    reg_transmit_format = 3'b011,
    bus_branch_format = 3'b100,
    bus_transmit_format = 3'b101,
    absolute_jump_format = 3'b110
  } format_t;
endpackage

// [quarter_sequencer.sv]
// Quarter-cycle counter and master timing strobe
`timescale 1ns/1ns
module quarter_sequencer
  import cycle_decode_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  output quarter_t quarter_out,
  output logic strobe_out
);
  typedef struct packed {
    quarter_t quarter;
    logic strobe;
  } seq_state_t;

  seq_state_t st;
  seq_state_t next_st;

  // Elaboration check: the counter below only serves four one-clock quarters
  if (QUARTERS_PER_CYCLE != 4 || QUARTER_CYCLES != 1) begin : g_bad_quarters
    $error("quarter_sequencer needs four one-clock quarters");
  end

  // Quarters advance every clock, wrapping after the fourth
  always_comb begin
    next_st = st;
    next_st.quarter = quarter_t'(st.quarter + 2'h1);
    next_st.strobe = (next_st.quarter == Q4);
  end

  // Reset lands in Q3 so the first address goes out before any fetch
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      st <= '{quarter: Q3, strobe: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign quarter_out = st.quarter;
  assign strobe_out = st.strobe;

  AST_STROBE_Q4: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    strobe_out == (quarter_out == Q4)) else $error("strobe outside fourth quarter");
  AST_QUARTER_ORDER: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    quarter_out == Q1 |=> quarter_out == Q2 ##1 quarter_out == Q3 ##1 quarter_out == Q4
      ##1 quarter_out == Q1) else $error("quarters out of order");
endmodule // quarter_sequencer

// [instr_field_decoder.sv]
// Splits an instruction word into opcode, format and operand fields
`timescale 1ns/1ns
module instr_field_decoder
  import cycle_decode_pkg::*;
(
  input wire logic [INSTR_W-1:0] instr_in,
  output opcode_t opcode_out,
  output format_t format_out,
  output logic [SEL_W-1:0] src_sel_out,
  output logic [2:0] rot_len_out,
  output logic [SEL_W-1:0] dst_sel_out,
  output logic [7:0] literal8_out,
  output logic [4:0] literal5_out,
  output logic [ADDR_W-1:0] jump_addr_out,
  output logic bus_source_out,
  output logic src_right_out,
  output logic addr_cmd_out,
  output logic data_cmd_out,
  output logic out_right_out
);
  logic [SEL_W-1:0] field_a;
  logic [SEL_W-1:0] field_c;

  // Fixed field slices
  assign opcode_out = opcode_t'(instr_in[OPCODE_MSB:OPCODE_LSB]);
  assign field_a = instr_in[SRC_MSB:SRC_LSB];
  assign field_c = instr_in[DST_MSB:DST_LSB];
  assign rot_len_out = instr_in[RL_MSB:RL_LSB];
  assign literal8_out = instr_in[LIT8_MSB:0];
  assign literal5_out = instr_in[LIT5_MSB:0];
  assign jump_addr_out = instr_in[ADDR_W-1:0];
  assign src_right_out = field_a[SEL_BANK_BIT];

  // Format and bus-use classification
  always_comb begin
    format_out = reg_reg_format;
    src_sel_out = field_a;
    dst_sel_out = field_c;
    bus_source_out = 1'b0;
    addr_cmd_out = 1'b0;
    data_cmd_out = 1'b0;
    out_right_out = 1'b0;
    case (opcode_out)
      op_move, op_add, op_and, op_xor: begin
        if (field_a[SEL_BUS_BIT] || field_c[SEL_BUS_BIT]) begin
          format_out = reg_bus_format;
          bus_source_out = field_a[SEL_BUS_BIT];
          data_cmd_out = field_c[SEL_BUS_BIT];
          addr_cmd_out = !field_c[SEL_BUS_BIT]
            && (field_c == REG_LEFT_ADDR || field_c == REG_RIGHT_ADDR);
          out_right_out = field_c[SEL_BANK_BIT];
        end
      end
      op_execute_indirect, op_branch_if_nonzero: begin
        format_out = field_a[SEL_BUS_BIT] ? bus_branch_format : reg_branch_format;
        bus_source_out = field_a[SEL_BUS_BIT];
      end
      op_transmit_literal: begin
        dst_sel_out = field_a;
        out_right_out = field_a[SEL_BANK_BIT];
        if (field_a[SEL_BUS_BIT]) begin
          format_out = bus_transmit_format;
          data_cmd_out = 1'b1;
        end else begin
          format_out = reg_transmit_format;
          addr_cmd_out = (field_a == REG_LEFT_ADDR || field_a == REG_RIGHT_ADDR);
          data_cmd_out = (field_a == REG_TRANSMIT_LITERAL_LEFT || field_a == REG_TRANSMIT_LITERAL_RIGHT);
          out_right_out = field_a[0];
          if (addr_cmd_out) begin
            out_right_out = field_a[SEL_BANK_BIT];
          end
        end
      end
      op_jump: begin
        format_out = absolute_jump_format;
      end
      default: begin
        format_out = reg_reg_format;
      end
    endcase
  end
endmodule // instr_field_decoder

// [instruction_cycle_fetch_decode.sv]
// Four-quarter instruction cycle: fetch, bus input, next address, strobed output
//
// Behaviour
// - In quarter one take the instruction word, decode it, latch it at quarter end.
// - Bus-source instructions read the inverted bus in quarter one under bus controls.
// - The bus input phase covers quarters one and two.
// - End of quarter two latches bus data into bus and ALU operand latches.
// - Quarter three drives the next fetch address; address latch open then.
// - Quarter three generates output controls and settles outgoing bus data.
// - Quarter four raises the master strobe; peripherals latch output on it.
// - Every instruction follows the same four-quarter sequence.
// - Branches compute the new program address before it is driven out.
// - Each instruction is one 16-bit word from program storage.
// - Eight classes, one opcode each, covering twenty-four variations.
// - Seven formats: reg-reg, reg-bus, reg branch, reg transmit, bus ones, jump.
// - Opcode in bits 0 to 2, operand fields in bits 3 to 15.
// - A cycle is half the external clock, four hidden quarters; here a cycle is four sys_clk periods, one per quarter.
// - The master strobe is high only in the final quarter.
// - Opcodes 0..7: move, add, and, xor, execute, branch-nonzero, transmit, jump.
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
module instruction_cycle_fetch_decode
  import cycle_decode_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [INSTR_W-1:0] instr_in,
  output logic [ADDR_W-1:0] prog_addr_out,
  input wire logic [DATA_W-1:0] bus_n_in,
  output logic [DATA_W-1:0] bus_n_out,
  output logic bus_n_oe_out,
  output logic select_cmd_out,
  output logic write_cmd_out,
  output logic left_bank_n_out,
  output logic right_bank_n_out,
  output logic master_timing_strobe_out,
  input wire logic [DATA_W-1:0] reg_src_data_in,
  input wire logic [DATA_W-1:0] out_data_in,
  output logic [INSTR_W-1:0] instr_word_out,
  output opcode_t opcode_out,
  output format_t format_out,
  output logic [SEL_W-1:0] src_sel_out,
  output logic [2:0] rot_len_out,
  output logic [SEL_W-1:0] dst_sel_out,
  output logic [7:0] literal8_out,
  output logic [DATA_W-1:0] bus_latch_out,
  output logic [DATA_W-1:0] alu_operand_out,
  output quarter_t quarter_out
);
  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [INSTR_W-1:0] instr_sync1;
    logic [INSTR_W-1:0] instr_sync2;
    logic [INSTR_W-1:0] instr;
    logic [DATA_W-1:0] bus_latch;
    logic [DATA_W-1:0] alu_operand;
    logic [ADDR_W-1:0] prog_addr;
    logic [DATA_W-1:0] bus_drive_n;
    logic bus_oe;
    logic sel_cmd;
    logic wr_cmd;
    logic out_left_n;
    logic out_right_n;
  } core_state_t;

  core_state_t st;
  core_state_t next_st;
  quarter_t quarter;
  logic strobe;
  logic [INSTR_W-1:0] cur_word;
  opcode_t opcode;
  format_t format;
  logic [SEL_W-1:0] src_sel;
  logic [SEL_W-1:0] dst_sel;
  logic [2:0] rot_len;
  logic [7:0] literal8;
  logic [4:0] literal5;
  logic [ADDR_W-1:0] jump_addr;
  logic bus_source;
  logic src_right;
  logic addr_cmd;
  logic data_cmd;
  logic out_right;
  logic in_phase;
  logic [DATA_W-1:0] bus_now;
  logic [ADDR_W-1:0] branch_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Timing generator and decode
  quarter_sequencer u_seq (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .quarter_out(quarter),
    .strobe_out(strobe)
  );

  // In quarter one the word still arriving is decoded, later the latched one
  assign cur_word = (quarter == Q1) ? st.instr_sync2 : st.instr;

  instr_field_decoder u_dec (
    .instr_in(cur_word),
    .opcode_out(opcode),
    .format_out(format),
    .src_sel_out(src_sel),
    .rot_len_out(rot_len),
    .dst_sel_out(dst_sel),
    .literal8_out(literal8),
    .literal5_out(literal5),
    .jump_addr_out(jump_addr),
    .bus_source_out(bus_source),
    .src_right_out(src_right),
    .addr_cmd_out(addr_cmd),
    .data_cmd_out(data_cmd),
    .out_right_out(out_right)
  );

  assign in_phase = (quarter == Q1) || (quarter == Q2);
  // Bus pins are low-true; flip once here for every consumer
  // Ports answer in step with our own quarters, so the bus is read unsynchronised:
  // two flops would make the quarter-two latch take data two quarters stale
  assign bus_now = ~bus_n_in;

  ////////////////////////////////////////////////////////////////////////////
  // Branch target, resolved before the address leaves in quarter three
  always_comb begin
    branch_addr = st.prog_addr + 13'h0001;
    case (opcode)
      op_jump: begin
        branch_addr = jump_addr;
      end
      op_branch_if_nonzero: begin
        if (format == reg_branch_format && reg_src_data_in != 8'h00) begin
          branch_addr = {st.prog_addr[ADDR_W-1:8], literal8};
        end else if (format == bus_branch_format && bus_now != 8'h00) begin
          branch_addr = {st.prog_addr[ADDR_W-1:5], literal5};
        end
      end
      default: begin
        branch_addr = st.prog_addr + 13'h0001;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic, one branch per quarter
  always_comb begin
    next_st = st;
    // Instruction pins pass two flops before anything reads them
    next_st.instr_sync1 = instr_in;
    next_st.instr_sync2 = st.instr_sync1;
    case (quarter)
      Q1: begin
        next_st.instr = st.instr_sync2;
      end
      Q2: begin
        // Both latches close together at the end of the input phase
        if (bus_source) begin
          next_st.bus_latch = bus_now;
          next_st.alu_operand = bus_now;
        end
        next_st.prog_addr = branch_addr;
        // Output controls come up with the address; register-only words stay idle
        if (format != reg_reg_format) begin
          next_st.sel_cmd = addr_cmd;
          next_st.wr_cmd = data_cmd;
          next_st.out_left_n = !((addr_cmd || data_cmd) && !out_right);
          next_st.out_right_n = !((addr_cmd || data_cmd) && out_right);
        end
      end
      Q3: begin
        // Data settled during quarter three is driven while the strobe is high
        if (st.sel_cmd || st.wr_cmd) begin
          next_st.bus_drive_n = ~out_data_in;
          next_st.bus_oe = 1'b1;
        end
      end
      Q4: begin
        // Release the bus as the cycle ends
        next_st.bus_oe = 1'b0;
        next_st.bus_drive_n = BUS_IDLE_N;
        next_st.sel_cmd = 1'b0;
        next_st.wr_cmd = 1'b0;
        next_st.out_left_n = 1'b1;
        next_st.out_right_n = 1'b1;
      end
      default: begin
        next_st = st;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      st <= '{instr_sync1: INSTR_RESET, instr_sync2: INSTR_RESET, instr: INSTR_RESET,
             bus_latch: 8'h00, alu_operand: 8'h00, prog_addr: PROG_ADDR_RESET,
             bus_drive_n: BUS_IDLE_N, bus_oe: 1'b0, sel_cmd: 1'b0, wr_cmd: 1'b0,
             out_left_n: 1'b1, out_right_n: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Input-phase bank enables follow the decoded source; output phase is registered
  assign left_bank_n_out = in_phase ? !(bus_source && !src_right) : st.out_left_n;
  assign right_bank_n_out = in_phase ? !(bus_source && src_right) : st.out_right_n;
  assign select_cmd_out = st.sel_cmd;
  assign write_cmd_out = st.wr_cmd;
  assign bus_n_out = st.bus_drive_n;
  assign bus_n_oe_out = st.bus_oe;
  assign master_timing_strobe_out = strobe;
  assign prog_addr_out = st.prog_addr;
  assign instr_word_out = st.instr;
  assign opcode_out = opcode;
  assign format_out = format;
  assign src_sel_out = src_sel;
  assign rot_len_out = rot_len;
  assign dst_sel_out = dst_sel;
  assign literal8_out = literal8;
  assign bus_latch_out = st.bus_latch;
  assign alu_operand_out = st.alu_operand;
  assign quarter_out = quarter;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_INSTR_HOLD: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    quarter != Q1 |=> $stable(instr_word_out)) else $error("instruction changed after quarter one");
  AST_ADDR_Q3: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    $changed(prog_addr_out) |-> quarter == Q3) else $error("address changed outside quarter three");
  AST_JUMP_TARGET: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    quarter == Q2 && opcode == op_jump |=> prog_addr_out == $past(jump_addr))
    else $error("jump target not driven");
  AST_SEQ_ADDR: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    quarter == Q2 && opcode == op_move |=> prog_addr_out == $past(prog_addr_out) + 13'h0001)
    else $error("sequential address wrong");
  AST_RR_IDLE: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    quarter == Q2 && format == reg_reg_format |-> !bus_n_oe_out ##1
      (!bus_n_oe_out && !select_cmd_out && !write_cmd_out && left_bank_n_out
       && right_bank_n_out) [*2]) else $error("register-only word used the bus");
  AST_INPUT_NO_DRIVE: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    in_phase |-> !bus_n_oe_out && !select_cmd_out && !write_cmd_out)
    else $error("bus driven during input phase");
  AST_OE_STROBE: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    bus_n_oe_out |-> master_timing_strobe_out && quarter == Q4)
    else $error("bus driven outside strobe quarter");
  AST_BUS_CAPTURE: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    quarter == Q2 && bus_source |=> bus_latch_out == $past(bus_now)
      && alu_operand_out == bus_latch_out) else $error("bus data not latched");
  AST_CMD_EXCL: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !(select_cmd_out && write_cmd_out)) else $error("both bus commands high");
  // An output command always names exactly one bank, never both or neither
  AST_BANK_OUT: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    quarter == Q3 && (select_cmd_out || write_cmd_out) |-> left_bank_n_out != right_bank_n_out)
    else $error("output command without a single bank");
  // The strobe quarter closes the cycle; the next one starts a fetch
  AST_STROBE_ENDS: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    master_timing_strobe_out |=> quarter == Q1 && !master_timing_strobe_out)
    else $error("cycle did not end with the strobe");

  COV_JUMP: cover property (@(posedge sys_clk_in) disable iff (reset_in)
    quarter == Q2 && opcode == op_jump);
  COV_BRANCH_TAKEN: cover property (@(posedge sys_clk_in) disable iff (reset_in)
    quarter == Q2 && opcode == op_branch_if_nonzero && branch_addr != st.prog_addr + 13'h0001);
  COV_BUS_WRITE: cover property (@(posedge sys_clk_in) disable iff (reset_in)
    bus_n_oe_out && write_cmd_out);
  COV_BUS_READ: cover property (@(posedge sys_clk_in) disable iff (reset_in)
    quarter == Q2 && bus_source && format == reg_bus_format);
  COV_REG_ONLY: cover property (@(posedge sys_clk_in) disable iff (reset_in)
    quarter == Q2 && format == reg_reg_format);
endmodule // instruction_cycle_fetch_decode

// [far_side_model.sv]
// Behavioural program memory and bus peripheral facing the instruction cycle block
`timescale 1ns/1ns
module far_side_model
  import cycle_decode_pkg::*;
#(
  parameter logic [7:0] PERIPH_BYTE = 8'h9D
) (
  input wire logic sys_clk_in,
  input wire logic [ADDR_W-1:0] prog_addr_in,
  output logic [INSTR_W-1:0] instr_out,
  input wire logic [DATA_W-1:0] bus_n_in,
  input wire logic bus_n_oe_in,
  input wire logic select_cmd_in,
  input wire logic write_cmd_in,
  input wire logic left_bank_n_in,
  input wire logic right_bank_n_in,
  input wire logic strobe_in,
  output logic [DATA_W-1:0] bus_n_out
);
  logic [INSTR_W-1:0] rom [0:63];
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] addr_data;
  logic [DATA_W-1:0] churn;
  logic reading;

  ////////////////////////////////////////////////////////////////////////////////
  // Program storage answers combinationally; the bench fills the array at time zero
  assign instr_out = (prog_addr_in < 13'h0040) ? rom[prog_addr_in[5:0]] : INSTR_RESET;

  // Selected port drives read data while enabled with both commands low
  assign reading = (!left_bank_n_in || !right_bank_n_in) && !select_cmd_in && !write_cmd_in;
  // Data held from the start of quarter one, so it is settled early in quarter two
  assign bus_n_out = reading ? ~PERIPH_BYTE : churn;

  ////////////////////////////////////////////////////////////////////////////////
  // Released bus shows a changing pattern so a stale byte can never pass as data
  initial begin
    churn = 8'h3C;
    wr_data = 8'h00;
    addr_data = 8'h00;
  end

  // Ports capture only on the master strobe, never on internal quarters
  always @(posedge sys_clk_in) begin
    churn <= ~churn ^ 8'h5A;
    if (strobe_in && bus_n_oe_in && write_cmd_in) wr_data <= ~bus_n_in;
    if (strobe_in && bus_n_oe_in && select_cmd_in) addr_data <= ~bus_n_in;
  end
endmodule // far_side_model

// [tb.sv]
// Self-checking bench for the four-quarter instruction cycle and its decoder
`timescale 1ns/1ns
module tb;
  import cycle_decode_pkg::*;
  typedef struct packed {
    logic [12:0] addr;
    logic [15:0] word;
    opcode_t op;
    format_t fmt;
    logic [12:0] next;
    logic [2:0] flags;
  } row_t;
  // Flags: 1 register-only, 2 bus source, 4 bus write
  localparam row_t ROWS [10] = '{
    '{13'h0000, 16'h0162, op_move, reg_reg_format, 13'h0001, 3'h1},
    '{13'h0001, 16'h30E3, op_add, reg_bus_format, 13'h0002, 3'h2},
    '{13'h0002, 16'h4158, op_and, reg_bus_format, 13'h0003, 3'h4},
    '{13'h0003, 16'h6405, op_xor, reg_reg_format, 13'h0004, 3'h1},
    '{13'h0004, 16'h8233, op_execute_indirect, reg_branch_format, 13'h0005, 3'h0},
    '{13'h0005, 16'hB0E6, op_branch_if_nonzero, bus_branch_format, 13'h0006, 3'h2},
    '{13'h0006, 16'hC35A, op_transmit_literal, reg_transmit_format, 13'h0007, 3'h0},
    '{13'h0007, 16'hE008, op_jump, absolute_jump_format, 13'h0008, 3'h0},
    '{13'h0008, 16'hA120, op_branch_if_nonzero, reg_branch_format, 13'h0020, 3'h0},
    '{13'h0020, 16'hD01F, op_transmit_literal, bus_transmit_format, 13'h0021, 3'h0}
  };
  localparam logic [7:0] PERIPH_BYTE = 8'h9D;
  localparam logic [7:0] OUT_BYTE = 8'hC6;
  logic sys_clk_in;
  logic reset_in;
  logic [INSTR_W-1:0] instr_in;
  logic [ADDR_W-1:0] prog_addr_out;
  logic [DATA_W-1:0] bus_wire;
  logic [DATA_W-1:0] periph_n;
  logic [DATA_W-1:0] bus_n_out;
  logic bus_n_oe_out;
  logic select_cmd_out;
  logic write_cmd_out;
  logic left_bank_n_out;
  logic right_bank_n_out;
  logic master_timing_strobe_out;
  logic [DATA_W-1:0] reg_src_data_in;
  logic [DATA_W-1:0] out_data_in;
  logic [INSTR_W-1:0] instr_word_out;
  opcode_t opcode_out;
  format_t format_out;
  logic [SEL_W-1:0] src_sel_out;
  logic [2:0] rot_len_out;
  logic [SEL_W-1:0] dst_sel_out;
  logic [7:0] literal8_out;
  logic [DATA_W-1:0] bus_latch_out;
  logic [DATA_W-1:0] alu_operand_out;
  quarter_t quarter_out;
  int errors = 0;
  int n_tests = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus level: the device wins while its enable is up, else the peripheral
  assign bus_wire = bus_n_oe_out ? bus_n_out : periph_n;

  instruction_cycle_fetch_decode u_dut (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .instr_in(instr_in),
    .prog_addr_out(prog_addr_out), .bus_n_in(bus_wire), .bus_n_out(bus_n_out),
    .bus_n_oe_out(bus_n_oe_out), .select_cmd_out(select_cmd_out),
    .write_cmd_out(write_cmd_out), .left_bank_n_out(left_bank_n_out),
    .right_bank_n_out(right_bank_n_out),
    .master_timing_strobe_out(master_timing_strobe_out),
    .reg_src_data_in(reg_src_data_in), .out_data_in(out_data_in),
    .instr_word_out(instr_word_out), .opcode_out(opcode_out), .format_out(format_out),
    .src_sel_out(src_sel_out), .rot_len_out(rot_len_out), .dst_sel_out(dst_sel_out),
    .literal8_out(literal8_out), .bus_latch_out(bus_latch_out),
    .alu_operand_out(alu_operand_out), .quarter_out(quarter_out));

  far_side_model #(.PERIPH_BYTE(PERIPH_BYTE)) u_far (
    .sys_clk_in(sys_clk_in), .prog_addr_in(prog_addr_out), .instr_out(instr_in),
    .bus_n_in(bus_wire), .bus_n_oe_in(bus_n_oe_out), .select_cmd_in(select_cmd_out),
    .write_cmd_in(write_cmd_out), .left_bank_n_in(left_bank_n_out),
    .right_bank_n_in(right_bank_n_out), .strobe_in(master_timing_strobe_out),
    .bus_n_out(periph_n));

  ////////////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end

  // Compare and count; four-state inequality so unknowns never match
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("Checks made %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Hold reset for six edges, check idle state after the fifth, then the first quarter after release
  task automatic apply_reset();
    @(posedge sys_clk_in);
    reset_in <= 1'b1;
    repeat (5) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    check("rst_ctl", {quarter_out, 6'b000011, bus_n_out} ^ {master_timing_strobe_out,
      bus_n_oe_out, select_cmd_out, write_cmd_out, left_bank_n_out, right_bank_n_out, 8'h00},
      {Q3, 6'b000000, BUS_IDLE_N});
    check("rst_addr", 16'(prog_addr_out), 16'(PROG_ADDR_RESET));
    check("rst_latch", {bus_latch_out, alu_operand_out}, 16'h0000);
    @(posedge sys_clk_in);
    reset_in <= 1'b0;
    @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    check("first_q", {14'h0000, quarter_out} + 16'(master_timing_strobe_out), 16'h0004);
  endtask

  // Walk every table row one quarter at a time, starting at a quarter one
  task automatic run_prog();
    row_t r;
    int k;
    k = 0;
    do begin
      @(negedge sys_clk_in);
      k++;
    end while (quarter_out !== Q1 && k < 8);
    for (int i = 0; i < 10; i++) begin
      r = ROWS[i];
      for (int q = 0; q < 4; q++) begin
        if (q > 0) @(negedge sys_clk_in);
        check("quarter", 16'(quarter_out), 16'(q));
        check("strobe", 16'(master_timing_strobe_out), 16'(q == 3));
        if (r.flags[0]) check("idle_bus", 16'({left_bank_n_out, right_bank_n_out, bus_n_oe_out,
          select_cmd_out, write_cmd_out}), 16'h0018);
        if (r.flags[1] && q < 2) check("src_bank", 16'(left_bank_n_out), 16'h0000);
        if (r.flags[1] && q == 2) check("latches", {bus_latch_out, alu_operand_out},
          {PERIPH_BYTE, PERIPH_BYTE});
        if (r.flags[2] && q == 2) check("wr_cmd", 16'(write_cmd_out), 16'h0001);
        if (r.flags[2] && q == 3) check("drive", 16'({bus_n_oe_out, bus_n_out}),
          16'({1'b1, ~OUT_BYTE}));
        if (q == 2) check("next_addr", 16'(prog_addr_out), 16'(r.next));
        if (q == 1) begin
          check("word", instr_word_out, r.word);
          check("opcode", 16'(opcode_out), 16'(r.op));
          check("format", 16'(format_out), 16'(r.fmt));
          if (r.op < op_execute_indirect) check("fields",
            16'({src_sel_out, rot_len_out, dst_sel_out}), 16'(r.word[12:0]));
          else if (r.op != op_jump) check("literal", 16'(literal8_out),
            16'(r.word[7:0]));
        end
      end
      @(negedge sys_clk_in);
      if (r.flags[2]) check("port_data", 16'(u_far.wr_data), 16'(OUT_BYTE));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: program load, run, reset in mid-instruction, run again
  initial begin
    reset_in = 1'b1;
    reg_src_data_in = 8'h01;
    out_data_in = OUT_BYTE;
    for (int i = 0; i < 64; i++) u_far.rom[i] = INSTR_RESET;
    for (int i = 0; i < 10; i++) u_far.rom[ROWS[i].addr[5:0]] = ROWS[i].word;
    apply_reset();
    run_prog();
    @(negedge sys_clk_in);
    apply_reset();
    run_prog();
    wrap_up();
  end

  // Watchdog: both runs need well under 200 cycles
  initial begin
    #(400 * 40);
    errors++;
    wrap_up();
  end
endmodule // tb
